//--- core/sse_pkg.sv
/*
  Constants and types shared by the supply sequencing state engine and its state memory.
  Assumes a single 50 MHz clock and an active-low asynchronous reset.
*/
package sse_pkg;

  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned N_STATES    = 63;
  localparam int unsigned N_PINS      = 8;
  localparam int unsigned IDX_W       = 6;
  localparam int unsigned DLY_W       = 16;

  // Delay units: one tick is 10 us; 400 ms is the longest delay.
  localparam int unsigned TICK_NS     = 10_000;
  localparam int unsigned TICK_CYC    = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned MAX_DLY_MS  = 400;
  localparam int unsigned MAX_TICKS   = MAX_DLY_MS * 100;

  // On-chip output clock of 100 kHz: half period in cycles.
  localparam int unsigned OCLK_HZ     = 100_000;
  localparam int unsigned OCLK_HALF   = CLK_HZ / (2 * OCLK_HZ);

  // A definition fetch must finish inside 20 us.
  localparam int unsigned LOAD_MAX_NS = 20_000;
  localparam int unsigned LOAD_CYC    = 2;

  // Sequence input select: 0..7 are the pins, this code is the warning.
  localparam logic [3:0]  SEL_WARN    = 4'h8;

  // Output source select per pin.
  localparam logic [1:0]  SRC_SEQ     = 2'h0;
  localparam logic [1:0]  SRC_DIRECT  = 2'h1;
  localparam logic [1:0]  SRC_CLOCK   = 2'h2;

  localparam logic [IDX_W-1:0] RESET_STATE = 6'h00;

  typedef struct packed {
    logic [N_PINS-1:0] outputs;
    logic              seq_en;
    logic [3:0]        seq_sel;
    logic              seq_level;
    logic [DLY_W-1:0]  seq_delay;
    logic [IDX_W-1:0]  seq_target;
    logic              tmo_en;
    logic [DLY_W-1:0]  tmo_delay;
    logic [IDX_W-1:0]  tmo_target;
    logic [N_PINS:0]   mon_mask;
    logic [N_PINS:0]   mon_expect;
    logic [IDX_W-1:0]  mon_target;
  } sse_def_t;

  // Sample program entries for the rail A enable and disable states.
  localparam logic [IDX_W-1:0] RAIL_A_ENABLE_STATE  = 6'h02;
  localparam logic [IDX_W-1:0] RAIL_A_DISABLE_STATE = 6'h03;
  localparam logic [IDX_W-1:0] RAIL_B_ENABLE_STATE  = 6'h04;
  localparam logic [IDX_W-1:0] IDLE_STATE           = 6'h00;
  localparam logic [DLY_W-1:0] RAIL_A_TMO_TICKS     = 16'h03e8;

  localparam sse_def_t RAIL_A_ENABLE_DEF = '{
    outputs: 8'h01, seq_en: 1'b1, seq_sel: 4'h1, seq_level: 1'b1, seq_delay: 16'h0000,
    seq_target: RAIL_B_ENABLE_STATE, tmo_en: 1'b1, tmo_delay: RAIL_A_TMO_TICKS,
    tmo_target: RAIL_A_DISABLE_STATE, mon_mask: 9'h001, mon_expect: 9'h001,
    mon_target: IDLE_STATE};

  localparam sse_def_t RAIL_A_DISABLE_DEF = '{
    outputs: 8'h06, seq_en: 1'b1, seq_sel: 4'h4, seq_level: 1'b1, seq_delay: 16'h0000,
    seq_target: IDLE_STATE, tmo_en: 1'b0, tmo_delay: 16'h0000,
    tmo_target: IDLE_STATE, mon_mask: 9'h000, mon_expect: 9'h000,
    mon_target: IDLE_STATE};

endpackage

//--- core/sse_mem_if.sv
/*
  Carrier between the sequencer and its state definition memory.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface sse_mem_if;
  logic                      rd_en;
  logic [5:0]                rd_addr;
  sse_pkg::sse_def_t         rd_data;
  logic                      wr_en;
  logic [5:0]                wr_addr;
  sse_pkg::sse_def_t         wr_data;

  modport ctl (output rd_en, output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
  modport mem (input rd_en, input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface

//--- core/sse_state_mem.sv
/*
  Store of the programmable state definitions with a registered read port.
  Assumes writes come from configuration logic on the same clock.
*/
`timescale 1ns/10ps
module sse_state_mem (
  input  wire logic clock_i,
  input  wire logic rstn_i,
  sse_mem_if.mem    bus
);

  sse_pkg::sse_def_t store [sse_pkg::N_STATES];

  ////////////////////////////////////////////////////////////////////////////
  // One entry per state; the rail A enable and disable states come up preloaded.
  for (genvar g = 0; g < sse_pkg::N_STATES; g++)
  begin : g_entry
    localparam sse_pkg::sse_def_t INIT =
      (g == int'(sse_pkg::RAIL_A_ENABLE_STATE))  ? sse_pkg::RAIL_A_ENABLE_DEF :
      (g == int'(sse_pkg::RAIL_A_DISABLE_STATE)) ? sse_pkg::RAIL_A_DISABLE_DEF : '0;
    wire logic hit = bus.wr_en && (bus.wr_addr == 6'(g));
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
      if (!rstn_i)
        store[g] <= INIT;
      else if (hit)
        store[g] <= bus.wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read; addresses past the last state read as zero.
  wire logic in_range = (bus.rd_addr < 6'(sse_pkg::N_STATES));

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      bus.rd_data <= '0;
    else if (bus.rd_en)
      bus.rd_data <= in_range ? store[bus.rd_addr] : '0;
  end

endmodule // sse_state_mem

//--- core/sse_sequencer.sv
/*
  State engine driving eight output pins from per-state definitions with three exit paths.
  Assumes supply detector and monitor inputs are asynchronous pins; jump, warning from ADC
  limits and configuration writes come from logic on the same 50 MHz clock.
*/
`timescale 1ns/10ps

module sse_sequencer (
  input  wire logic                      clock_i,
  input  wire logic                      rstn_i,
  input  wire logic [7:0]                supply_fault_detector_i,
  input  wire logic [7:0]                sec_monitor_i,
  input  wire logic                      adc_limit_warn_i,
  input  wire logic                      jump_i,
  input  wire logic [7:0]                direct_bits_i,
  input  wire logic [15:0]               pin_src_sel_i,
  input  wire logic                      cfg_we_i,
  input  wire logic [5:0]                cfg_addr_i,
  input  wire sse_pkg::sse_def_t         cfg_data_i,
  output logic      [7:0]                programmable_drive_output_o,
  output logic      [5:0]                cur_state_o,
  output logic                           loading_o,
  output logic      [7:0]                sec_status_o,
  output logic                           warning_o
);

  typedef enum logic [1:0] {ST_FETCH, ST_WAIT, ST_RUN} sse_phase_t;

  sse_mem_if mem_bus ();

  sse_state_mem u_mem (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .bus     (mem_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for pin inputs.
  logic [7:0]        sfd_meta;
  logic [7:0]        sfd_sync;
  logic [7:0]        sec_meta;
  logic [7:0]        sec_sync;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sfd_meta <= '0;
      sfd_sync <= '0;
      sec_meta <= '0;
      sec_sync <= '0;
    end
    else
    begin
      sfd_meta <= supply_fault_detector_i;
      sfd_sync <= sfd_meta;
      sec_meta <= sec_monitor_i;
      sec_sync <= sec_meta;
    end
  end

  wire logic       warn_any = adc_limit_warn_i | (|sec_sync);
  wire logic [8:0] inputs   = {warn_any, sfd_sync};

  ////////////////////////////////////////////////////////////////////////////
  // Phase control and current definition.
  sse_pkg::sse_def_t def;
  sse_phase_t        phase;
  logic [5:0]        cur;
  logic [5:0]        next_cur;
  logic              jump_seen;
  logic [8:0]        tick_pre;
  logic [15:0]       seq_cnt;
  logic [15:0]       tmo_cnt;
  logic [7:0]        seq_level;

  wire logic       run      = (phase == ST_RUN);
  wire logic       tick     = (tick_pre == 9'(sse_pkg::TICK_CYC - 1));
  wire logic       seq_in   = (def.seq_sel == sse_pkg::SEL_WARN) ? warn_any : inputs[def.seq_sel[2:0]];
  wire logic       seq_cond = def.seq_en && (seq_in == def.seq_level);
  wire logic       seq_go   = seq_cond && (seq_cnt >= def.seq_delay);
  wire logic       mon_go   = |((inputs ^ def.mon_expect) & def.mon_mask);
  wire logic       tmo_go   = def.tmo_en && (tmo_cnt >= def.tmo_delay);
  wire logic       exit_now = run && (mon_go || tmo_go || seq_go || jump_seen);

  always_comb
  begin
    next_cur = cur;
    if (mon_go)
      next_cur = def.mon_target;
    else if (tmo_go)
      next_cur = def.tmo_target;
    else if (seq_go || jump_seen)
      next_cur = def.seq_target;
  end

  assign mem_bus.rd_en   = (phase == ST_FETCH);
  assign mem_bus.rd_addr = cur;
  assign mem_bus.wr_en   = cfg_we_i;
  assign mem_bus.wr_addr = cfg_addr_i;
  assign mem_bus.wr_data = cfg_data_i;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      phase     <= ST_FETCH;
      cur       <= sse_pkg::RESET_STATE;
      def       <= '0;
      seq_level <= '0;
    end
    else
    begin
      case (phase)
        ST_FETCH: phase <= ST_WAIT;
        ST_WAIT:
        begin
          phase     <= ST_RUN;
          def       <= mem_bus.rd_data;
          seq_level <= mem_bus.rd_data.outputs;
        end
        ST_RUN:
        begin
          if (exit_now)
          begin
            cur   <= next_cur;
            phase <= ST_FETCH;
          end
        end
        default: phase <= ST_FETCH;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Jump capture: a jump during a load is kept and acts once running.
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      jump_seen <= 1'b0;
    else if (jump_i)
      jump_seen <= 1'b1;
    else if (exit_now)
      jump_seen <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay timers in 10 us ticks, cleared on every state change.
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tick_pre <= '0;
      seq_cnt  <= '0;
      tmo_cnt  <= '0;
    end
    else if (!run)
    begin
      tick_pre <= '0;
      seq_cnt  <= '0;
      tmo_cnt  <= '0;
    end
    else
    begin
      tick_pre <= tick ? 9'h000 : tick_pre + 9'h001;
      if (!seq_cond)
        seq_cnt <= '0;
      else if (tick && seq_cnt != 16'hffff)
        seq_cnt <= seq_cnt + 16'h0001;
      if (tick && tmo_cnt != 16'hffff)
        tmo_cnt <= tmo_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 100 kHz output clock and per-pin source selection.
  logic [7:0] oclk_cnt;
  logic       oclk;

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      oclk_cnt <= '0;
      oclk     <= 1'b0;
    end
    else if (oclk_cnt == 8'(sse_pkg::OCLK_HALF - 1))
    begin
      oclk_cnt <= '0;
      oclk     <= ~oclk;
    end
    else
      oclk_cnt <= oclk_cnt + 8'h01;
  end

  logic [7:0] next_pins;

  for (genvar p = 0; p < sse_pkg::N_PINS; p++)
  begin : g_pin
    wire logic [1:0] src = pin_src_sel_i[2*p +: 2];
    assign next_pins[p] = (src == sse_pkg::SRC_DIRECT) ? direct_bits_i[p] :
                          (src == sse_pkg::SRC_CLOCK)  ? oclk : seq_level[p];
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      programmable_drive_output_o <= '0;
      cur_state_o                 <= sse_pkg::RESET_STATE;
      loading_o                   <= 1'b1;
      sec_status_o                <= '0;
      warning_o                   <= 1'b0;
    end
    else
    begin
      programmable_drive_output_o <= next_pins;
      cur_state_o                 <= cur;
      loading_o                   <= !run;
      sec_status_o                <= sec_sync;
      warning_o                   <= warn_any;
    end
  end

endmodule // sse_sequencer

//--- test/sse_props.sv
/*
  Port checker for the sequencer.
  Assumes the bench keeps pin 7 on the on-chip clock source.
*/
`timescale 1ns/10ps
module sse_props (
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  sec_monitor_i,
  input wire logic        adc_limit_warn_i,
  input wire logic        jump_i,
  input wire logic [7:0]  direct_bits_i,
  input wire logic [15:0] pin_src_sel_i,
  input wire logic [7:0]  programmable_drive_output_o,
  input wire logic        loading_o,
  input wire logic [7:0]  sec_status_o,
  input wire logic        warning_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence s_run;
    !loading_o && $stable(pin_src_sel_i) && pin_src_sel_i[13:0] == 14'h0000;
  endsequence
  sequence s_direct;
    !loading_o && pin_src_sel_i[1:0] == sse_pkg::SRC_DIRECT && $stable(direct_bits_i[0]);
  endsequence
  sequence s_clock_sel;
    pin_src_sel_i[15:14] == sse_pkg::SRC_CLOCK;
  endsequence
  a_out_hold: assert property (s_run [*3] |-> $stable(programmable_drive_output_o[6:0]))
    else $error("outputs moved inside a state");
  a_load_bounded: assert property ($rose(loading_o) |-> ##[1:999] !loading_o)
    else $error("definition load too long");
  a_jump_load: assert property (jump_i && !loading_o |-> ##[1:4] loading_o)
    else $error("jump did not start a load");
  a_warn_set: assert property (adc_limit_warn_i [*2] |-> warning_o)
    else $error("warning missing");
  a_warn_clear: assert property ((!adc_limit_warn_i && sec_monitor_i == 8'h00) [*4] |-> !warning_o)
    else $error("warning without cause");
  a_sec_status: assert property ($stable(sec_monitor_i) [*4] |-> sec_status_o == sec_monitor_i)
    else $error("secondary status wrong");
  a_direct_pin: assert property (s_direct [*3] |-> programmable_drive_output_o[0] == direct_bits_i[0])
    else $error("direct pin level wrong");
  a_clock_pin: assert property (s_clock_sel [*3] |-> ##[1:520] $changed(programmable_drive_output_o[7]))
    else $error("clock pin not toggling");
endmodule // sse_props

bind sse_sequencer sse_props sse_props_inst (.clock_i, .rstn_i, .sec_monitor_i, .adc_limit_warn_i, .jump_i,
  .direct_bits_i, .pin_src_sel_i, .programmable_drive_output_o, .loading_o, .sec_status_o, .warning_o);

//--- test/sse_rail_model.sv
/*
  Supply rail model feeding the fault detector inputs.
  Assumes the bench switches rails and injects faults.
*/
`timescale 1ns/10ps
module sse_rail_model #(parameter int ON_DLY = 4) (
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] rail_on_i,
  input  wire logic [7:0] fault_i,
  output logic      [7:0] detector_o
);
  int cnt [8];
  // A rail reports good once on for a while and drops at once on a fault.
  always @(posedge clock_i or negedge rstn_i)
    for (int i = 0; i < 8; i++)
      if (!rstn_i || !rail_on_i[i]) cnt[i] <= 0;
      else if (cnt[i] < ON_DLY) cnt[i] <= cnt[i] + 1;
  always_comb
    for (int i = 0; i < 8; i++)
      detector_o[i] = (cnt[i] == ON_DLY) && !fault_i[i];
endmodule // sse_rail_model

//--- test/sse_sequencer_tb.sv
/*
  Self-checking bench for the sequencer.
  Assumes the rail model on the detector inputs and a 50 MHz clock.
*/
`timescale 1ns/10ps
module sse_sequencer_tb;
  logic clock_i, rstn_i, adc, jump, we, load, warn;
  logic [7:0] rail_on, fault, det, sec, dir, programmable_drive_output, secst;
  logic [15:0] sel;
  logic [5:0] addr, cur;
  sse_pkg::sse_def_t data;
  int failures, n_tests, cyc;

  sse_rail_model sse_rail_model_inst (.clock_i(clock_i), .rstn_i(rstn_i), .rail_on_i(rail_on), .fault_i(fault),
    .detector_o(det));
  sse_sequencer sse_sequencer_inst (.clock_i(clock_i), .rstn_i(rstn_i), .supply_fault_detector_i(det),
    .sec_monitor_i(sec), .adc_limit_warn_i(adc), .jump_i(jump), .direct_bits_i(dir), .pin_src_sel_i(sel),
    .cfg_we_i(we), .cfg_addr_i(addr), .cfg_data_i(data), .programmable_drive_output_o(programmable_drive_output),
    .cur_state_o(cur), .loading_o(load), .sec_status_o(secst), .warning_o(warn));

  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) cyc <= cyc + 1;

  function automatic logic [7:0] exp_pins(logic [7:0] o, logic [7:0] d, logic [15:0] s);
    exp_pins = 8'h00;
    for (int p = 0; p < 7; p++)
      exp_pins[p] = (s[2*p +: 2] == sse_pkg::SRC_DIRECT) ? d[p] : o[p];
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic pulse_jump;
    jump <= 1'b1;
    tick(1);
    jump <= 1'b0;
    tick(12);
  endtask
  task automatic wr(logic [5:0] a, sse_pkg::sse_def_t d);
    we <= 1'b1;
    addr <= a;
    data <= d;
    tick(1);
    we <= 1'b0;
    tick(1);
  endtask
  task automatic wait_load(logic v);
    int n;
    n = 0;
    while (load !== v && n < 2000)
    begin
      tick(1);
      n++;
    end
    if (n == 2000) chk(8'h00, 8'h01);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    sse_pkg::sse_def_t d;
    logic [5:0] st [6];
    int dly [6];
    logic [7:0] outs [6];
    int t0, dl;
    logic [15:0] src;
    {adc, jump, we, addr, data, sec, dir, failures, n_tests, cyc} = '0;
    rstn_i = 1'b0;
    sel = 16'h8000;
    rail_on = 8'h03;
    fault = 8'h02;
    void'($urandom(54));
    tick(6);
    rstn_i <= 1'b1;
    tick(10);
    chk(8'(cur), 8'h00);
    chk(programmable_drive_output & 8'h7f, 8'h00);
    $display("test reset done");
    d = '0;
    d.seq_target = 6'h02;
    wr(6'h00, d);
    pulse_jump;
    chk(8'(cur), 8'h00);
    pulse_jump;
    chk(8'(cur), 8'h02);
    chk(programmable_drive_output & 8'h7f, exp_pins(sse_pkg::RAIL_A_ENABLE_DEF.outputs, dir, sel));
    fault <= 8'h01;
    tick(5);
    chk(8'(cur), 8'h00);
    tick(7);
    chk(8'(cur), 8'h00);
    fault <= 8'h02;
    pulse_jump;
    chk(8'(cur), 8'h02);
    fault <= 8'h00;
    tick(12);
    chk(8'(cur), 8'h04);
    $display("test exits done");
    for (int i = 0; i < 6; i++) st[i] = 6'(10 + 8 * i + $urandom_range(0, 7));
    for (int i = 0; i < 6; i++)
    begin
      d = '0;
      d.outputs = 8'($urandom);
      d.tmo_en = 1'b1;
      d.tmo_delay = 16'($urandom_range(1, 3));
      d.tmo_target = (i == 5) ? 6'h00 : st[i+1];
      dly[i] = d.tmo_delay;
      outs[i] = d.outputs;
      wr(st[i], d);
    end
    for (int p = 0; p < 7; p++) src[2*p +: 2] = ($urandom_range(0, 1) == 1) ? 2'h1 : 2'h3;
    src[1:0] = sse_pkg::SRC_DIRECT;
    src[15:14] = sse_pkg::SRC_CLOCK;
    sel <= src;
    dir <= 8'($urandom);
    d = '0;
    d.seq_target = st[0];
    wr(6'h00, d);
    pulse_jump;
    jump <= 1'b1;
    tick(1);
    jump <= 1'b0;
    wait_load(1'b1);
    for (int i = 0; i < 6; i++)
    begin
      wait_load(1'b0);
      t0 = cyc;
      chk(8'(cur), 8'(st[i]));
      chk(programmable_drive_output & 8'h7f, exp_pins(outs[i], dir, sel));
      wait_load(1'b1);
      dl = cyc - t0;
      chk(8'(dl >= dly[i] * 500 - 2 && dl <= dly[i] * 500 + 4), 8'h01);
    end
    wait_load(1'b0);
    chk(8'(cur), 8'h00);
    $display("test timeout chain done");
    sec <= 8'($urandom_range(1, 255));
    tick(6);
    chk(secst, sec);
    chk(8'(warn), 8'h01);
    sec <= 8'h00;
    adc <= 1'b1;
    tick(6);
    chk(8'(warn), 8'h01);
    adc <= 1'b0;
    tick(6);
    chk(8'(warn), 8'h00);
    $display("test warnings done");
    end_of_test;
  end

  initial
  begin
    #1_000_000;
    failures++;
    end_of_test;
  end
endmodule // sse_sequencer_tb
